// ### logic/tws_pkg.sv
// Shared constants for the three-wire clocked serial transceiver.
// Assumes a 250 MHz system clock and a quasi-static mode configuration.
package tws_pkg;
	localparam int TWS_DATA_W = 8; // Bits per transfer unit
	localparam int TWS_EDGE_W = 4; // Edge counter width, 16 clock edges per unit
	localparam int TWS_CNT_W = 4; // Width of the bit and half-period counters
	localparam logic [3:0] TWS_LAST_EDGE = 4'hF; // Final edge of a unit
	localparam logic [3:0] TWS_LAST_BIT = 4'h7; // Index of the eighth bit
	localparam logic [2:0] TWS_CLK_SRC_EXT = 3'h7; // Clock source code for slave
	localparam int TWS_CLK_MHZ = 250; // System clock rate
	localparam int TWS_HALF_NS = 16; // Master serial clock half period, ns
	localparam int TWS_HALF_CYC_I = (TWS_HALF_NS * TWS_CLK_MHZ) / 1000; // Rounded down
	localparam logic [3:0] TWS_HALF_CYC = 4'(TWS_HALF_CYC_I < 1 ? 1 : TWS_HALF_CYC_I);
	localparam logic [7:0] TWS_DATA_RST = 8'h00; // Reset value of data registers
	localparam logic [3:0] TWS_CNT_RST = 4'h0; // Reset value of counters
	localparam int TWS_SYNC_W = 3; // Synchroniser width: select, data in, done
	typedef enum logic [0:0] {
		TWS_IDLE,
		TWS_RUN
	} tws_mst_e;
endpackage

// ### logic/tws_sync.sv
// Two-flop synchroniser bank for levels entering the system clock domain.
// Assumes each bit is an independent level; no bus coherency is provided.
`timescale 1ns/1ps
`default_nettype none
module tws_sync import tws_pkg::*; #(
	parameter int W = TWS_SYNC_W
) (
	input wire logic i_clk, // System clock
	input wire logic i_reset, // Synchronous reset, active high
	input wire logic [W-1:0] i_async, // Levels from another domain
	output logic [W-1:0] o_sync // Synchronised levels
);
	logic [W-1:0] meta_ff; // First stage, read only by second stage
	logic [W-1:0] sync_ff; // Second stage

	// Plain double flop; first stage feeds nothing but the second
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule
`default_nettype wire

// ### logic/tws_core.sv
// Three-wire clocked serial transceiver: master and slave byte engine.
// Assumes mode inputs stay still while busy and the external master
// keeps the serial clock idle outside a frame.
// Operation
// - Eight bits per unit, clocked by serial clock
// - Buffer write starts transmit/receive when mode=1
// - Shift register read starts receive when mode=0
// - Slave select low allows start when enabled
// - Slave select high blocks any new start
// - Blocked start stays pending until select low
// - Select rising mid-transfer suspends the transfer
// - Busy on start; done flag, busy clear
// - Disable stops operation, releases all pins
// - Clock out as master, in as slave
// - Select used only in slave operation
// - Four clock/phase types; MSB first by default
// - Phase 0: first bit at first launch edge
// - Phase 0: later bits on later launch edges
// - Phase 1: first bit at access strobe
// - Phase 1: later bits on opposite edges
// - Disable resets busy flag and shift register
// - Data out holds last bit after unit
// - Disabled, mode=1, phase 1: out shows buffer end bit
`timescale 1ns/1ps
`default_nettype none
module tws_core import tws_pkg::*; (
	input wire logic i_clk, // System clock, 250 MHz
	input wire logic i_reset, // Synchronous reset, active high
	input wire logic i_operation_enable, // Serial operation on
	input wire logic i_transfer_mode_select, // 1 transmit/receive, 0 receive only
	input wire logic i_slave_select_enable, // Honour slave select in slave mode
	input wire logic i_bit_order_select, // 0 MSB first, 1 LSB first
	input wire logic i_clock_polarity, // Serial clock polarity
	input wire logic i_data_phase, // Data phase
	input wire logic [2:0] i_clock_source_sel, // All ones selects external clock
	input wire logic i_transmit_buffer_wr, // Buffer write strobe, one cycle
	input wire logic [7:0] i_transmit_buffer, // Buffer write data
	input wire logic i_shift_reg_rd, // Shift register read strobe, one cycle
	input wire logic i_irq_ack, // Clears the done flag, one cycle
	input wire logic i_serial_clock_line, // Serial clock pin input, link clock
	input wire logic i_serial_data_in, // Serial data pin input
	input wire logic i_slave_select_in_n, // Slave select pin, active low
	output logic o_serial_clock_line, // Serial clock pin output
	output logic o_serial_clock_oe, // Serial clock pin drive enable
	output logic o_serial_data_out, // Serial data pin output
	output logic o_serial_data_oe, // Serial data pin drive enable
	output logic [7:0] o_serial_shift_register, // Received byte
	output logic o_transfer_busy_flag, // Transfer in progress
	output logic o_transfer_done_irq_flag // Sticky completion flag
);
	// ---- System domain state ----
	tws_mst_e state_ff, nxt_state; // Master engine state
	logic [7:0] txbuf_ff; // Transmit buffer
	logic [7:0] rx_ff; // Received byte seen by software
	logic [7:0] m_shreg_ff; // Master shift register
	logic [3:0] m_half_ff; // Master half-period counter
	logic [3:0] m_edge_ff; // Master edge index
	logic m_sck_ff; // Master serial clock
	logic sck_oe_ff; // Clock pin enable
	logic so_oe_ff; // Data pin enable
	logic so_ff; // System-side data out latch
	logic busy_ff; // Busy flag
	logic irq_ff; // Done flag
	logic pend_ff; // Start held by slave select
	logic start_tgl_ff; // Start event toward link domain
	logic link_rst_ff; // Reset for link domain
	logic done_seen_ff; // Last synchronised done level
	logic [TWS_SYNC_W-1:0] sync_w; // Synchronised pins and done toggle

	// ---- Link domain state ----
	logic [7:0] l_shreg_ff; // Slave shift register
	logic [3:0] l_bit_ff; // Slave captured bit count
	logic l_cap_seen_ff; // Capture side frame marker
	logic l_done_tgl_ff; // Done event toward system domain
	logic l_so_ff; // Slave launch latch
	logic l_launch_seen_ff; // Launch side frame marker

	// ---- Decodes ----
	// Slave whenever the clock source code picks the external clock
	wire is_slave = (i_clock_source_sel == TWS_CLK_SRC_EXT);
	wire ss_gate = is_slave && i_slave_select_enable;
	// Synchronised levels; the select level is high while deselected
	wire ss_high_s = sync_w[2];
	wire si_s = sync_w[1];
	wire done_lvl = sync_w[0];
	// The transfer mode names which access starts a unit
	wire access = i_transfer_mode_select ? i_transmit_buffer_wr : i_shift_reg_rd;
	wire req = i_operation_enable && !busy_ff && access;
	// A blocked start waits in pend_ff until the select pin falls
	wire ss_block = ss_gate && ss_high_s;
	wire go_now = (req || pend_ff) && !ss_block;
	wire slave_done = done_lvl != done_seen_ff;
	// Master timing: one half period every TWS_HALF_CYC cycles
	wire half_end = (m_half_ff == TWS_HALF_CYC - 4'h1);
	// Even edge steps launch and odd ones capture; phase 1 swaps them
	wire m_is_cap = m_edge_ff[0] ^ i_data_phase; // Capture edge of this step
	wire m_first_cap = (m_edge_ff[3:1] == 3'h0);
	wire m_last = (m_edge_ff == TWS_LAST_EDGE);
	wire m_done = (state_ff == TWS_RUN) && half_end && m_last;
	// Bypass so a strobe latch sees the byte written in the same cycle
	wire [7:0] start_buf = i_transmit_buffer_wr ? i_transmit_buffer : txbuf_ff;

	// Bit picked for output from a byte under the current order
	function automatic logic first_bit(input logic [7:0] b, input logic lsb);
		first_bit = lsb ? b[0] : b[7];
	endfunction

	// Loads a byte and shifts one step, inserting the received bit
	function automatic logic [7:0] shift_in(input logic [7:0] b, input logic lsb,
		input logic si);
		shift_in = lsb ? {si, b[7:1]} : {b[6:0], si};
	endfunction

	// Master FSM next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			TWS_IDLE: begin
				if (go_now && !is_slave) begin
					nxt_state = TWS_RUN;
				end
			end
			TWS_RUN: begin
				if (m_done || !i_operation_enable) begin
					nxt_state = TWS_IDLE;
				end
			end
		endcase
	end

	// Transmit buffer holds the last written byte
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			txbuf_ff <= TWS_DATA_RST;
		end else if (i_transmit_buffer_wr) begin
			txbuf_ff <= i_transmit_buffer;
		end
	end

	// Busy, pending and start event
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_operation_enable) begin
			busy_ff <= 1'b0;
			pend_ff <= 1'b0;
			start_tgl_ff <= 1'b0;
		end else begin
			if (req && ss_block) begin
				pend_ff <= 1'b1;
			end else if (go_now) begin
				pend_ff <= 1'b0;
			end
			if (go_now) begin
				busy_ff <= 1'b1;
				start_tgl_ff <= ~start_tgl_ff;
			end else if (m_done || (is_slave && slave_done)) begin
				busy_ff <= 1'b0;
			end
		end
	end

	// Done flag: a new completion wins over acknowledge
	// Slave completion counts only while a unit is running
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			irq_ff <= 1'b0;
		end else if (m_done || (is_slave && slave_done && busy_ff)) begin
			irq_ff <= 1'b1;
		end else if (i_irq_ack) begin
			irq_ff <= 1'b0;
		end
	end

	// Received byte register and done edge tracking
	// With phase 0 the master's eighth bit comes straight from the synchroniser
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_operation_enable) begin
			rx_ff <= TWS_DATA_RST;
			done_seen_ff <= done_lvl;
		end else begin
			done_seen_ff <= done_lvl;
			if (m_done) begin
				rx_ff <= m_is_cap ? shift_in(m_shreg_ff, i_bit_order_select, si_s)
					: m_shreg_ff;
			end else if (is_slave && slave_done) begin
				rx_ff <= l_shreg_ff; // Link side is still after its last edge
			end
		end
	end

	// Master clock divider and edge stepping
	// Counter restarts at each half period end, so halves stay equal
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_ff <= TWS_IDLE;
			m_half_ff <= TWS_CNT_RST;
			m_edge_ff <= TWS_CNT_RST;
			m_sck_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == TWS_RUN && !half_end) begin
				m_half_ff <= m_half_ff + 4'h1;
			end else begin
				m_half_ff <= TWS_CNT_RST;
			end
			if (state_ff == TWS_IDLE) begin
				m_edge_ff <= TWS_CNT_RST;
				m_sck_ff <= ~i_clock_polarity; // Idle level per polarity
			end else if (half_end) begin
				m_edge_ff <= m_edge_ff + 4'h1;
				m_sck_ff <= ~m_sck_ff;
			end
		end
	end

	// Master shift register: first capture loads buffer and shifts once
	// With phase 0 the last capture goes to rx_ff instead, so the register takes no eighth shift
	always_ff @(posedge i_clk) begin
		if (i_reset || !i_operation_enable) begin
			m_shreg_ff <= TWS_DATA_RST;
		end else if (state_ff == TWS_RUN && half_end && m_is_cap && !m_last) begin
			m_shreg_ff <= shift_in(m_first_cap ? txbuf_ff : m_shreg_ff,
				i_bit_order_select, si_s);
		end
	end

	// System-side data out latch, also the disabled-state level
	// Priority: disabled level, receive-only low, strobe, clock edges
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			so_ff <= 1'b0;
		end else if (!i_operation_enable) begin
			so_ff <= i_transfer_mode_select && i_data_phase
				&& first_bit(txbuf_ff, i_bit_order_select);
		end else if (!i_transfer_mode_select) begin
			so_ff <= 1'b0; // Receive only, output unused
		end else if (go_now && i_data_phase) begin
			so_ff <= first_bit(start_buf, i_bit_order_select);
		end else if (state_ff == TWS_RUN && half_end && !m_is_cap) begin
			if (m_edge_ff == TWS_CNT_RST) begin
				so_ff <= first_bit(txbuf_ff, i_bit_order_select);
			end else if (!m_last) begin
				so_ff <= first_bit(m_shreg_ff, i_bit_order_select);
			end
		end
	end

	// Pin enables; disabled block drives nothing
	// Link reset comes from a flop so that it never glitches
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			sck_oe_ff <= 1'b0;
			so_oe_ff <= 1'b0;
			link_rst_ff <= 1'b1;
		end else begin
			sck_oe_ff <= i_operation_enable && !is_slave;
			so_oe_ff <= i_operation_enable && i_transfer_mode_select;
			link_rst_ff <= !i_operation_enable;
		end
	end

	// Select, data in and done toggle into the system domain
	// Select goes in as the pin level: high means deselected
	tws_sync #(
		.W(TWS_SYNC_W)
	) u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async({i_slave_select_in_n, i_serial_data_in, l_done_tgl_ff}),
		.o_sync(sync_w)
	);

	// ---- Link domain ----
	// Capture edge is rising when polarity equals phase; the inversion
	// is a static mux, so no glitch while the clock is idle.
	wire cap_clk = i_serial_clock_line ^ (i_clock_polarity ^ i_data_phase);
	// Select reaches the link domain raw: the master moves it a clock
	// period ahead of any edge, so it is settled when sampled
	wire l_hold = ss_gate && i_slave_select_in_n;
	wire l_new_cap = (l_cap_seen_ff != start_tgl_ff); // Stable before first edge
	wire l_new_launch = (l_launch_seen_ff != start_tgl_ff);

	// Slave capture side: bit count, shift register, done event
	// Count parks at eight, so clocks past the unit are ignored
	always_ff @(posedge cap_clk or posedge link_rst_ff) begin
		if (link_rst_ff) begin
			l_shreg_ff <= TWS_DATA_RST;
			l_bit_ff <= TWS_CNT_RST;
			l_cap_seen_ff <= 1'b0;
			l_done_tgl_ff <= 1'b0;
		end else if (!l_hold && busy_ff) begin
			if (l_new_cap) begin
				l_shreg_ff <= shift_in(txbuf_ff, i_bit_order_select,
					i_serial_data_in);
				l_bit_ff <= 4'h1;
				l_cap_seen_ff <= start_tgl_ff;
			end else if (l_bit_ff != 4'h8) begin
				l_shreg_ff <= shift_in(l_shreg_ff, i_bit_order_select, i_serial_data_in);
				l_bit_ff <= l_bit_ff + 4'h1;
				if (l_bit_ff == TWS_LAST_BIT) begin
					l_done_tgl_ff <= ~l_done_tgl_ff;
				end
			end
		end
	end

	// Slave launch side on the opposite edge
	// First launch of a unit comes from the buffer or the loaded register
	always_ff @(negedge cap_clk or posedge link_rst_ff) begin
		if (link_rst_ff) begin
			l_so_ff <= 1'b0;
			l_launch_seen_ff <= 1'b0;
		end else if (!l_hold && busy_ff) begin
			if (l_new_launch) begin
				l_launch_seen_ff <= start_tgl_ff;
				l_so_ff <= i_data_phase ? first_bit(l_shreg_ff, i_bit_order_select)
					: first_bit(txbuf_ff, i_bit_order_select);
			end else if (l_bit_ff != 4'h8) begin
				l_so_ff <= first_bit(l_shreg_ff, i_bit_order_select);
			end
		end
	end

	// Data pin: slave path once its launch side owns the frame
	// Kept as a mux: a system-clock flop would delay the slave bit
	wire slave_owns = is_slave && i_operation_enable && i_transfer_mode_select
		&& !l_new_launch;

	assign o_serial_data_out = slave_owns ? l_so_ff : so_ff;
	// Remaining outputs are the flops themselves
	assign o_serial_clock_line = m_sck_ff;
	assign o_serial_clock_oe = sck_oe_ff;
	assign o_serial_data_oe = so_oe_ff;
	assign o_serial_shift_register = rx_ff;
	assign o_transfer_busy_flag = busy_ff;
	assign o_transfer_done_irq_flag = irq_ff;
endmodule
`default_nettype wire

// ### tb/tws_core_props.sv
// Port assertions for the serial transceiver core.
// Assumes a bind to tws_core and one system clock domain.
`timescale 1ns/1ps
`default_nettype none
module tws_core_props import tws_pkg::*; (
	input wire logic i_clk, // Clock
	input wire logic i_reset, // Reset
	input wire logic i_operation_enable, // Enable
	input wire logic i_transfer_mode_select, // Mode
	input wire logic i_slave_select_enable, // Select use
	input wire logic [2:0] i_clock_source_sel, // Source
	input wire logic i_transmit_buffer_wr, // Write
	input wire logic i_irq_ack, // Ack
	input wire logic i_slave_select_in_n, // Select
	input wire logic o_serial_clock_oe, // Clock drive
	input wire logic o_serial_data_oe, // Data drive
	input wire logic [7:0] o_serial_shift_register, // Rx byte
	input wire logic o_transfer_busy_flag, // Busy
	input wire logic o_transfer_done_irq_flag // Done
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire mst = i_clock_source_sel != TWS_CLK_SRC_EXT; // Master clocking
	wire rdy = i_operation_enable && !o_transfer_busy_flag; // Free for a request
	chk_write_start: assert property (rdy && mst && i_transfer_mode_select
		&& i_transmit_buffer_wr |=> o_transfer_busy_flag) else $error("write did not start");
	// Sixteen half periods of four cycles, a little slack for the edges
	chk_unit_length: assert property ($rose(o_transfer_busy_flag) && mst
		|-> ##[60:70] $fell(o_transfer_busy_flag)) else $error("unit length wrong");
	chk_done_at_end: assert property ($fell(o_transfer_busy_flag) && i_operation_enable
		&& $past(i_operation_enable) |-> o_transfer_done_irq_flag) else $error("no done flag");
	chk_done_sticky: assert property (o_transfer_done_irq_flag && !i_irq_ack
		&& i_operation_enable |=> o_transfer_done_irq_flag) else $error("done flag lost");
	chk_disable_reset: assert property (!i_operation_enable |=> !o_transfer_busy_flag
		&& o_serial_shift_register == TWS_DATA_RST) else $error("not reset on disable");
	chk_pins_released: assert property (!i_operation_enable
		|=> !o_serial_clock_oe && !o_serial_data_oe) else $error("pins still driven");
	chk_clock_dir: assert property (i_operation_enable |=> o_serial_clock_oe == $past(mst))
		else $error("clock direction wrong");
	// Four cycles high lets the select synchroniser settle first
	chk_select_blocks: assert property (i_slave_select_in_n [*4] ##0 (rdy && !mst
		&& i_slave_select_enable && i_transmit_buffer_wr) |=> !o_transfer_busy_flag)
		else $error("start while deselected");
endmodule
bind tws_core tws_core_props i_props (.i_clk(i_clk), .i_reset(i_reset),
	.i_operation_enable(i_operation_enable), .i_transfer_mode_select(i_transfer_mode_select),
	.i_slave_select_enable(i_slave_select_enable), .i_clock_source_sel(i_clock_source_sel),
	.i_transmit_buffer_wr(i_transmit_buffer_wr), .i_irq_ack(i_irq_ack),
	.i_slave_select_in_n(i_slave_select_in_n), .o_serial_clock_oe(o_serial_clock_oe),
	.o_serial_data_oe(o_serial_data_oe), .o_serial_shift_register(o_serial_shift_register),
	.o_transfer_busy_flag(o_transfer_busy_flag),
	.o_transfer_done_irq_flag(o_transfer_done_irq_flag));
`default_nettype wire

// ### tb/tws_far_model.sv
// Far party: a serial peripheral to our master, an external master to our slave.
// Assumes the bench calls load before each unit and ext_frame for slave units.
`timescale 1ns/1ps
`default_nettype none
module tws_far_model (
	input wire logic i_sck_out, // Block clock output
	input wire logic i_sck_oe, // Block clock drive
	input wire logic i_so, // Block data output
	input wire logic i_pol, // Clock polarity
	input wire logic i_pha, // Data phase
	output logic o_sck, // Clock level on the line
	output logic o_si, // Data into the block
	output var logic o_sel_n // Select, active low
);
	logic ext_sck = 1'b1; // Own clock, still outside frames
	logic [7:0] sh = 8'h00; // Outgoing bits, top bit on the line
	logic [7:0] rx = 8'h00; // Captured bits
	int ncap = 0; // Captures in this unit
	initial o_sel_n = 1'b1;
	assign o_sck = i_sck_oe ? i_sck_out : ext_sck; // Whoever drives the clock
	assign o_si = sh[7];
	// Capture on the same edge as the block, launch on the other
	always @(o_sck) begin
		if (o_sck === (i_pol ~^ i_pha)) begin
			rx = {rx[6:0], i_so};
			ncap++;
		end else if (i_pha || ncap != 0) begin
			sh = {sh[6:0], ~sh[0]}; // Changing fill, never a stale copy
		end
	end
	// Idle level first, so its edge does not disturb the fresh unit
	task automatic load(input logic [7:0] b);
		ext_sck = ~i_pol;
		#1;
		sh = b;
		rx = 8'h00;
		ncap = 0;
	endtask
	// Free clock edges at 12 ns period, select left as it stands
	task automatic clk_burst(input int edges);
		repeat (edges) begin
			#6;
			ext_sck = ~ext_sck;
		end
	endtask
	// Select low two link periods ahead, then a burst
	task automatic ext_frame(input int edges);
		#1.3 o_sel_n = 1'b0;
		#24;
		clk_burst(edges);
		#12 o_sel_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// ### tb/three_wire_clocked_serial_tb_top.sv
// Self-checking bench for the serial transceiver core.
// Assumes the far model beside it and the checker bound to the core.
`timescale 1ns/1ps
`default_nettype none
module three_wire_clocked_serial_tb_top;
	logic i_clk = 1'b0, i_reset = 1'b1, en = 1'b0, mode = 1'b0, sse = 1'b0, order = 1'b0;
	logic pol = 1'b0, pha = 1'b0, wr = 1'b0, rd = 1'b0, ack = 1'b0; // Strobes idle low
	logic [2:0] src = 3'h0; // Clock source code
	logic [7:0] txd = 8'h00, pre = 8'h00; // Our byte, far byte
	wire sck_o, sck_oe, so, so_oe, busy, done, sck, si, sel_n;
	wire [7:0] rxd;
	int err_count = 0, num_checks = 0, cyc = 0;
	tws_core i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_operation_enable(en),
		.i_transfer_mode_select(mode), .i_slave_select_enable(sse), .i_bit_order_select(order),
		.i_clock_polarity(pol), .i_data_phase(pha), .i_clock_source_sel(src),
		.i_transmit_buffer_wr(wr), .i_transmit_buffer(txd), .i_shift_reg_rd(rd),
		.i_irq_ack(ack), .i_serial_clock_line(sck), .i_serial_data_in(si),
		.i_slave_select_in_n(sel_n), .o_serial_clock_line(sck_o), .o_serial_clock_oe(sck_oe),
		.o_serial_data_out(so), .o_serial_data_oe(so_oe), .o_serial_shift_register(rxd),
		.o_transfer_busy_flag(busy), .o_transfer_done_irq_flag(done));
	tws_far_model i_far (.i_sck_out(sck_o), .i_sck_oe(sck_oe), .i_so(so), .i_pol(pol),
		.i_pha(pha), .o_sck(sck), .o_si(si), .o_sel_n(sel_n));
	initial forever #2 i_clk = ~i_clk;
	// Hang guard
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] rev(input logic [7:0] b);
		for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
	endfunction
	// One-cycle write or read strobe
	task automatic pulse(input logic w);
		@(negedge i_clk);
		{wr, rd} = {w, !w};
		@(negedge i_clk);
		{wr, rd} = 2'h0;
	endtask
	task automatic wait_done();
		for (int n = 0; n < 400 && done !== 1'b1; n++) @(negedge i_clk);
		chk(8'({busy, done}), 8'h01);
	endtask
	task automatic ack_done();
		@(negedge i_clk);
		ack = 1'b1;
		@(negedge i_clk);
		ack = 1'b0;
		chk(8'(done), 8'h00);
	endtask
	// Mode bits change only while idle, then the far side is loaded
	task automatic setup(input logic [2:0] s, input logic m, p, h, o, input logic [7:0] b);
		@(negedge i_clk);
		{src, mode, pol, pha, order, en} = {s, m, p, h, o, 1'b1};
		sse = (s == 3'h7);
		pre = b;
		@(negedge i_clk);
		i_far.load(b);
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge i_clk);
		i_reset = 1'b0;
		chk(8'({busy, done, so_oe, sck_oe}), 8'h00);
		// Master: four clock types, then reversed bit order
		for (int t = 0; t < 5; t++) begin
			txd = 8'hC3 + 8'(t);
			setup(3'h0, 1'b1, t[0], t[1], t[2], 8'h5A ^ 8'(t));
			pulse(1'b1);
			wait_done();
			chk(i_far.rx, t[2] ? rev(txd) : txd);
			chk(rxd, t[2] ? rev(pre) : pre);
			chk(8'(so), 8'(t[2] ? txd[7] : txd[0]));
			ack_done();
		end
		// Receive only: a write is ignored, a read starts
		setup(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h96);
		pulse(1'b1);
		repeat (4) @(negedge i_clk);
		chk(8'(busy), 8'h00);
		pulse(1'b0);
		wait_done();
		chk(rxd, 8'h96);
		ack_done();
		// Slave: write while deselected stays pending
		txd = 8'h81;
		setup(3'h7, 1'b1, 1'b1, 1'b0, 1'b0, 8'h3E);
		pulse(1'b1);
		repeat (6) @(negedge i_clk);
		chk(8'(busy), 8'h00);
		fork
			i_far.ext_frame(16);
			begin
				repeat (10) @(negedge i_clk);
				chk(8'(busy), 8'h01);
			end
		join
		wait_done();
		chk(i_far.rx, 8'h81);
		chk(rxd, 8'h3E);
		ack_done();
		// Slave: select rises mid-unit, then disable
		setup(3'h7, 1'b1, 1'b0, 1'b1, 1'b0, 8'h0F);
		pulse(1'b1);
		i_far.ext_frame(6);
		i_far.clk_burst(12); // Clocks for another slave must not move this one
		repeat (20) @(negedge i_clk);
		chk(8'({busy, done}), 8'h02);
		pol = 1'b0;
		en = 1'b0;
		repeat (2) @(negedge i_clk);
		chk(8'({busy, sck_oe, so_oe}), 8'h00);
		chk(rxd, 8'h00);
		chk(8'(so), 8'(txd[7]));
		close_out();
	end
endmodule
`default_nettype wire
